// ### rtl/ofw_bank.sv
// per-space overflow interrupt write configuration and write issue
`timescale 1ns/100ps
module ofw_bank (
    input wire logic core_clk, // clock
    input wire logic rst, // synchronous reset, active high
    input wire logic partitioning_rev_1_1_feature, // revision 1.1 present
    input wire logic overflow_write_supported, // support flag in monitor_feature_id_reg
    input wire logic realm_extension_feature, // realm extension present
    input wire logic reg_sel, // register access strobe
    input wire logic reg_write, // 1 write, 0 read
    input wire logic [1:0] reg_space, // feature frame the access came through
    input wire logic [11:0] reg_offset, // offset in the feature frame
    input wire logic [31:0] reg_wdata, // write data
    output logic [31:0] reg_rdata, // read data
    output logic reg_rvalid, // read data valid pulse
    input wire logic [3:0] overflow_event, // overflow pulse per space
    output logic [3:0] hardwired_irq, // hardwired overflow interrupt per space
    output logic write_valid, // interrupt write request
    input wire logic write_ready, // interconnect accepts the write
    output logic [51:0] write_addr, // write address
    output logic [31:0] write_data, // write payload
    output logic [1:0] write_space, // security space of the write
    output logic [3:0] write_memory_type, // issued memory type
    output logic [1:0] write_shareability, // issued shareability
    output logic [15:0] write_partition_identifier, // partition label
    output logic [7:0] write_monitoring_group // monitoring group label
);
    logic [31:0] addr_low [ofw_pkg::SPACES];
    logic [31:0] addr_high [ofw_pkg::SPACES];
    logic [31:0] payload [ofw_pkg::SPACES];
    logic [31:0] labels [ofw_pkg::SPACES];
    logic [31:0] attributes [ofw_pkg::SPACES];
    logic [3:0] pending;
    logic [3:0] enable_vec;
    logic present;
    logic space_ok;
    logic [1:0] pick;
    logic pick_any;
    logic [3:0] dec_mem;
    logic [1:0] dec_sh;
    ofw_pkg::ofw_state_t state;

    function automatic logic [3:0] onehot(input logic [1:0] s);
        onehot = 4'h1 << s;
    endfunction

    assign present = partitioning_rev_1_1_feature & overflow_write_supported;
    assign space_ok = (reg_space != ofw_pkg::SPACE_ROOT) | realm_extension_feature;

    always_comb begin
        for (int i = 0; i < ofw_pkg::SPACES; i++) begin
            enable_vec[i] = attributes[i][ofw_pkg::POS_ENABLE];
        end
    end

    // register writes, each space its own copy
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < ofw_pkg::SPACES; i++) begin
                attributes[i] <= 32'(ofw_pkg::RESET_ENABLE) << ofw_pkg::POS_ENABLE;
            end
        end else if (reg_sel && reg_write && present && space_ok) begin
            case (reg_offset)
                ofw_pkg::OFF_ATTRIBUTES: attributes[reg_space] <= reg_wdata & ofw_pkg::MASK_ATTRIBUTES;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reg_sel && reg_write && present && space_ok) begin
            case (reg_offset)
                ofw_pkg::OFF_ADDR_LOW: addr_low[reg_space] <= reg_wdata & ofw_pkg::MASK_ADDR_LOW;
                ofw_pkg::OFF_ADDR_HIGH: addr_high[reg_space] <= reg_wdata & ofw_pkg::MASK_ADDR_HIGH;
                ofw_pkg::OFF_PAYLOAD: payload[reg_space] <= reg_wdata;
                ofw_pkg::OFF_LABELS: labels[reg_space] <= reg_wdata & ofw_pkg::MASK_LABELS;
                default: begin
                end
            endcase
        end
    end

    // reads: absent or unmapped reads return zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_sel & ~reg_write;
            reg_rdata <= 32'h0000_0000;
            if (reg_sel && !reg_write && present && space_ok) begin
                case (reg_offset)
                    ofw_pkg::OFF_ADDR_LOW: reg_rdata <= addr_low[reg_space];
                    ofw_pkg::OFF_ADDR_HIGH: reg_rdata <= addr_high[reg_space];
                    ofw_pkg::OFF_PAYLOAD: reg_rdata <= payload[reg_space];
                    ofw_pkg::OFF_LABELS: reg_rdata <= labels[reg_space];
                    ofw_pkg::OFF_ATTRIBUTES: reg_rdata <= attributes[reg_space];
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // hardwired line only when writes are disabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hardwired_irq <= 4'h0;
        end else begin
            hardwired_irq <= overflow_event & ~(enable_vec & {4{present}});
        end
    end

    // lowest pending space first
    always_comb begin
        pick = 2'h0;
        pick_any = 1'b0;
        for (int i = ofw_pkg::SPACES - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick = 2'(i);
                pick_any = 1'b1;
            end
        end
    end

    ofw_attr_decode u_decode (
        .shareability(attributes[pick][ofw_pkg::POS_SH +: 2]),
        .memory_type(attributes[pick][ofw_pkg::POS_MEMTYPE +: 4]),
        .issued_memory_type(dec_mem),
        .issued_shareability(dec_sh),
        .is_device()
    );

    // pending per space: a new overflow wins over the clear of a sent one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pending <= 4'h0;
        end else begin
            pending <= ((pending & ~((state == ofw_pkg::OFW_SEND && write_ready) ? onehot(write_space) : 4'h0))
                | (overflow_event & enable_vec & {4{present}})) & enable_vec;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= ofw_pkg::OFW_IDLE;
            write_valid <= 1'b0;
            write_addr <= 52'h0;
            write_data <= 32'h0;
            write_space <= 2'h0;
            write_memory_type <= 4'h0;
            write_shareability <= 2'h0;
            write_partition_identifier <= 16'h0;
            write_monitoring_group <= 8'h0;
        end else begin
            case (state)
                ofw_pkg::OFW_IDLE: begin
                    if (pick_any) begin
                        state <= ofw_pkg::OFW_SEND;
                        write_valid <= 1'b1;
                        write_space <= pick;
                        write_addr <= {addr_high[pick][19:0], addr_low[pick][31:2], 2'b00};
                        write_data <= payload[pick];
                        write_memory_type <= dec_mem;
                        write_shareability <= dec_sh;
                        write_partition_identifier <= labels[pick][15:0];
                        write_monitoring_group <= labels[pick][23:16];
                    end
                end
                ofw_pkg::OFW_SEND: begin
                    if (write_ready) begin
                        state <= ofw_pkg::OFW_IDLE;
                        write_valid <= 1'b0;
                    end
                end
                default: begin
                    state <= ofw_pkg::OFW_IDLE;
                    write_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ### rtl/ofw_pkg.sv
// constants for the overflow interrupt write configuration bank
package ofw_pkg;
    localparam int unsigned SPACES = 4;
    localparam logic [1:0] SPACE_SECURE = 2'h0;
    localparam logic [1:0] SPACE_NONSECURE = 2'h1;
    localparam logic [1:0] SPACE_ROOT = 2'h2;
    localparam logic [1:0] SPACE_REALM = 2'h3;
    localparam logic [11:0] OFF_LABELS = 12'h8dc;
    localparam logic [11:0] OFF_ADDR_LOW = 12'h8e0;
    localparam logic [11:0] OFF_ADDR_HIGH = 12'h8e4;
    localparam logic [11:0] OFF_PAYLOAD = 12'h8e8;
    localparam logic [11:0] OFF_ATTRIBUTES = 12'h8ec;
    localparam logic [31:0] MASK_ADDR_LOW = 32'hffff_fffc;
    localparam logic [31:0] MASK_ADDR_HIGH = 32'h000f_ffff;
    localparam logic [31:0] MASK_ATTRIBUTES = 32'h3f00_0001;
    localparam logic [31:0] MASK_LABELS = 32'h00ff_ffff;
    localparam int unsigned POS_SH = 28;
    localparam int unsigned POS_MEMTYPE = 24;
    localparam int unsigned POS_ENABLE = 0;
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic [1:0] SH_NON = 2'h0;
    localparam logic [1:0] SH_OUTER = 2'h2;
    localparam logic [1:0] SH_INNER = 2'h3;
    localparam logic [3:0] MEM_DEV_NGNRNE = 4'h0;
    localparam logic [1:0] POLICY_DEVICE = 2'h0;
    typedef enum logic [1:0] {
        OFW_IDLE = 2'b00,
        OFW_SEND = 2'b01
    } ofw_state_t;
endpackage

// ### rtl/ofw_attr_decode.sv
// decodes stored write attributes into the attributes issued with a write
`timescale 1ns/100ps
module ofw_attr_decode (
    input wire logic [1:0] shareability, // stored shareability field
    input wire logic [3:0] memory_type, // stored memory type field
    output logic [3:0] issued_memory_type, // effective memory type
    output logic [1:0] issued_shareability, // effective shareability
    output logic is_device // effective type is a device type
);
    always_comb begin
        // reserved codes with non-device outer policy and device inner are issued as Device-nGnRnE
        if (memory_type[3:2] != ofw_pkg::POLICY_DEVICE && memory_type[1:0] == ofw_pkg::POLICY_DEVICE) begin
            issued_memory_type = ofw_pkg::MEM_DEV_NGNRNE;
        end else begin
            issued_memory_type = memory_type;
        end
        is_device = (issued_memory_type[3:2] == ofw_pkg::POLICY_DEVICE);
        if (is_device) begin
            issued_shareability = ofw_pkg::SH_OUTER;
        end else if (shareability == 2'h1) begin
            // reserved code taken as non-shareable
            issued_shareability = ofw_pkg::SH_NON;
        end else begin
            issued_shareability = shareability;
        end
    end
endmodule

// ### bench/ofw_bank_asserts.sv
// port assertions for the overflow write bank
`timescale 1ns/100ps
module ofw_bank_asserts (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic partitioning_rev_1_1_feature, // rev
    input wire logic overflow_write_supported, // flag
    input wire logic reg_sel, // strobe
    input wire logic reg_write, // write
    input wire logic [11:0] reg_offset, // offset
    input wire logic [31:0] reg_rdata, // rdata
    input wire logic reg_rvalid, // rvalid
    input wire logic [3:0] hardwired_irq, // irq
    input wire logic write_valid, // request
    input wire logic write_ready, // accept
    input wire logic [51:0] write_addr, // address
    input wire logic [3:0] write_memory_type, // type
    input wire logic [1:0] write_shareability // share
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence rd_req; reg_sel && !reg_write; endsequence
    sequence held_req; write_valid && !write_ready; endsequence
    read_answer_a: assert property (rd_req |=> reg_rvalid) else $error("read answer missing");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_sel && !reg_write)) else $error("stray rvalid");
    low_align_a: assert property (rd_req ##0 reg_offset == ofw_pkg::OFF_ADDR_LOW |=> reg_rdata[1:0] == 2'h0)
        else $error("low bits set");
    attr_reserved_a: assert property (rd_req ##0 reg_offset == ofw_pkg::OFF_ATTRIBUTES
        |=> (reg_rdata & ~ofw_pkg::MASK_ATTRIBUTES) == 32'h0) else $error("reserved bits set");
    absent_zero_a: assert property (rd_req ##0 !(partitioning_rev_1_1_feature && overflow_write_supported)
        |=> reg_rdata == 32'h0) else $error("absent read nonzero");
    write_hold_a: assert property (held_req |=> write_valid && $stable(write_addr)) else $error("write dropped");
    addr_align_a: assert property (write_valid |-> write_addr[1:0] == 2'h0) else $error("write unaligned");
    device_outer_a: assert property (write_valid && write_memory_type[3:2] == 2'h0
        |-> write_shareability == 2'h2) else $error("device not outer");
    no_reserved_a: assert property (write_valid |-> write_shareability != 2'h1
        && !(write_memory_type[1:0] == 2'h0 && write_memory_type != 4'h0)) else $error("reserved code issued");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !write_valid && hardwired_irq == 4'h0)
        else $error("output after reset");
endmodule
bind ofw_bank ofw_bank_asserts u_ofw_bank_asserts (.core_clk, .rst, .partitioning_rev_1_1_feature,
    .overflow_write_supported, .reg_sel, .reg_write, .reg_offset, .reg_rdata, .reg_rvalid, .hardwired_irq,
    .write_valid, .write_ready, .write_addr, .write_memory_type, .write_shareability);

// ### bench/ofw_irq_sink.sv
// interrupt controller stand-in accepting writes promptly or slowly
`timescale 1ns/100ps
module ofw_irq_sink (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic write_valid, // request
    input wire logic slow, // stall before accepting
    output logic write_ready // accept pulse
);
    logic [1:0] wait_cnt;
    always_ff @(posedge core_clk) begin
        if (rst || !write_valid || write_ready) begin
            wait_cnt <= 2'h0;
            write_ready <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
            write_ready <= !slow || wait_cnt == 2'h2;
        end
    end
endmodule

// ### bench/tb_top.sv
// testbench for the overflow write bank
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 1'b0, rst = 1'b1, rev = 1'b1, sup = 1'b1, rlm = 1'b1, slow = 1'b0, sel = 1'b0, wr = 1'b0;
    logic [1:0] sp = 2'h0, wspace, wsh;
    logic [11:0] off = 12'h0;
    logic [31:0] wd = 32'h0, rdata, wdata;
    logic rvalid, wvalid, wready;
    logic [3:0] ev = 4'h0, hw, wmt;
    logic [51:0] waddr;
    logic [15:0] wpart;
    logic [7:0] wgrp;
    logic [31:0] rq[$];
    logic [115:0] wq[$];
    logic [3:0] hq[$];
    int bad_count = 0, check_count = 0, seed = 32'hcc24;
    ofw_bank u_ofw_bank (.core_clk, .rst, .partitioning_rev_1_1_feature(rev), .overflow_write_supported(sup),
        .realm_extension_feature(rlm), .reg_sel(sel), .reg_write(wr), .reg_space(sp), .reg_offset(off),
        .reg_wdata(wd), .reg_rdata(rdata), .reg_rvalid(rvalid), .overflow_event(ev), .hardwired_irq(hw),
        .write_valid(wvalid), .write_ready(wready), .write_addr(waddr), .write_data(wdata), .write_space(wspace),
        .write_memory_type(wmt), .write_shareability(wsh), .write_partition_identifier(wpart),
        .write_monitoring_group(wgrp));
    ofw_irq_sink u_ofw_irq_sink (.core_clk, .rst, .write_valid(wvalid), .slow, .write_ready(wready));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk_rdata(input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] reg_rdata expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_irq(input logic [3:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] hardwired_irq expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_write(input logic [115:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] write expected %h seen %h", e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] s, input logic [11:0] o, input logic [31:0] d, e);
        sel = 1'b1;
        wr = w;
        sp = s;
        off = o;
        wd = d;
        if (!w) rq.push_back(e);
        @(posedge core_clk);
        #1 sel = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(input logic [1:0] s, input logic e);
        ev = 4'h1 << s;
        @(posedge core_clk);
        #1 ev = 4'h0;
        // the registered line shows the event at the next falling edge, for that one cycle only
        hq.push_back(e ? (4'h1 << s) : 4'h0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(negedge core_clk) begin
        if (rvalid) chk_rdata(rq.pop_front(), rdata);
        if (hq.size() > 0) chk_irq(hq.pop_front(), hw);
        if (wvalid && wready) chk_write(wq.pop_front(), {waddr, wdata, wspace, wmt, wsh, wpart, wgrp});
    end
    initial begin
        logic [31:0] lo, hi, pl, lb, at;
        logic [31:0] last_lo [4];
        logic [3:0] mt;
        logic [1:0] s, sh;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 20; i++) begin
            lo = $random(seed);
            hi = $random(seed);
            pl = $random(seed);
            lb = $random(seed);
            at = $random(seed);
            s = i[1:0];
            slow = i[2];
            at[27:24] = i[3:0];
            at[0] = i < 16;
            mt = (at[25:24] == 2'h0) ? 4'h0 : at[27:24];
            sh = (mt[3:2] == 2'h0) ? 2'h2 : (at[29:28] == 2'h1 ? 2'h0 : at[29:28]);
            acc(1'b1, s, ofw_pkg::OFF_ADDR_LOW, lo, 32'h0);
            acc(1'b1, s, ofw_pkg::OFF_ADDR_HIGH, hi, 32'h0);
            acc(1'b1, s, ofw_pkg::OFF_PAYLOAD, pl, 32'h0);
            acc(1'b1, s, ofw_pkg::OFF_LABELS, lb, 32'h0);
            acc(1'b1, s, ofw_pkg::OFF_ATTRIBUTES, at, 32'h0);
            acc(1'b0, s, ofw_pkg::OFF_ADDR_LOW, 32'h0, lo & 32'hffff_fffc);
            acc(1'b0, s, ofw_pkg::OFF_ATTRIBUTES, 32'h0, at & 32'h3f00_0001);
            acc(1'b0, s, ofw_pkg::OFF_ADDR_HIGH, 32'h0, hi & 32'h000f_ffff);
            acc(1'b0, s, ofw_pkg::OFF_PAYLOAD, 32'h0, pl);
            acc(1'b0, s, ofw_pkg::OFF_LABELS, 32'h0, lb & 32'h00ff_ffff);
            last_lo[s] = lo & 32'hffff_fffc;
            if (at[0]) wq.push_back({hi[19:0], lo[31:2], 2'h0, pl, s, mt, sh, lb[15:0], lb[23:16]});
            pulse(s, !at[0]);
            for (int k = 0; k < 40 && wq.size() > 0; k++) @(posedge core_clk);
            if (wq.size() > 0) begin
                bad_count++;
                test_done();
            end
            #1;
        end
        // each space still holds its own last address: no write leaked across
        for (int j = 0; j < 4; j++) acc(1'b0, 2'(j), ofw_pkg::OFF_ADDR_LOW, 32'h0, last_lo[j]);
        rlm = 1'b0;
        acc(1'b1, ofw_pkg::SPACE_ROOT, ofw_pkg::OFF_ADDR_LOW, 32'hffff_ffff, 32'h0);
        acc(1'b0, ofw_pkg::SPACE_ROOT, ofw_pkg::OFF_ADDR_LOW, 32'h0, 32'h0);
        rlm = 1'b1;
        acc(1'b0, ofw_pkg::SPACE_ROOT, ofw_pkg::OFF_ADDR_LOW, 32'h0, last_lo[2]);
        rev = 1'b0;
        acc(1'b0, ofw_pkg::SPACE_NONSECURE, ofw_pkg::OFF_ATTRIBUTES, 32'h0, 32'h0);
        rev = 1'b1;
        acc(1'b0, ofw_pkg::SPACE_SECURE, 12'h8f0, 32'h0, 32'h0);
        // enable space 1 so that only the reset can turn its writes off
        acc(1'b1, 2'h1, ofw_pkg::OFF_ATTRIBUTES, 32'h0000_0001, 32'h0);
        rst = 1'b1;
        @(posedge core_clk);
        #1 rst = 1'b0;
        pulse(2'h1, 1'b1);
        repeat (3) @(posedge core_clk);
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
